//--- src/hbc_core.sv
/*
 * Control logic of a two-input full-bridge motor driver: command decode,
 * fixed off-time mixed-decay chopping, synchronous rectification,
 * standby timer and protection gating of the four bridge gates.
 * Assumes all inputs are synchronous to clk_sys_in; analog comparators
 * (current trip, zero current, thermal, undervoltage, short) are
 * digitised outside. Thermal hysteresis lives in the thermal sensor.
 */
`timescale 1ns/1ps
module hbc_core
    import hbc_pkg::*;
#(
    parameter int unsigned STANDBY_CYC = STANDBY_CYC_DEF  // Standby delay
)(
    input  wire logic clk_sys_in,            // System clock, 25 MHz
    input  wire logic reset_in,              // Async reset, high
    input  wire logic dir_input_a_in,        // Direction input A
    input  wire logic dir_input_b_in,        // Direction input B
    input  wire logic current_trip_in,       // 10x sense above reference
    input  wire logic zero_current_in,       // Load current near zero
    input  wire logic short_fault_protect_in, // Short or overcurrent seen
    input  wire logic thermal_shutdown_in,   // Die too hot
    input  wire logic supply_low_lockout_in, // Load supply too low
    input  wire logic load_supply_restart_in, // Load supply power cycled
    output logic      bridge_out_a_hi_out,   // High-side gate, output A
    output logic      bridge_out_a_lo_out,   // Low-side gate, output A
    output logic      bridge_out_b_hi_out,   // High-side gate, output B
    output logic      bridge_out_b_lo_out,   // Low-side gate, output B
    output logic      charge_pump_en_out,    // Charge pump enable
    output logic      regulator_en_out,      // Internal regulator enable
    output logic      standby_out,           // Low-power standby active
    output logic      fault_out              // Overcurrent fault latched
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam logic [STBY_W-1:0] STBY_LIMIT = STBY_W'(STANDBY_CYC);

    hbc_state_type     state_r;
    hbc_state_type     state_nxt;
    logic              dir_fwd_r;
    logic              dir_fwd_nxt;
    logic [STBY_W-1:0] stby_cnt_r;
    logic              fault_r;
    logic              power_en_r;
    logic [3:0]        gate_r;
    logic              tmr_load;
    logic [TMR_W-1:0]  tmr_value;
    logic              tmr_done;
    logic              cmd_fwd;
    logic              cmd_rev;
    logic              cmd_drive;
    logic              cmd_brake;
    logic              cmd_coast;
    logic              stby_enter;
    logic              stby_leave;
    logic              blocked;

    // ------------------------------------------------------------------
    // Gate pattern for a state
    // ------------------------------------------------------------------
    function automatic logic [3:0] drive_fn(
        input hbc_state_type st,
        input logic          fwd,
        input logic          brake,
        input logic          zc
    );
        logic [3:0] g;
        g = GATE_OFF;
        case (st)
            ST_IDLE: begin
                g = brake ? GATE_BRAKE : GATE_OFF;
            end
            ST_ON: begin
                g = fwd ? GATE_FWD : GATE_REV;
            end
            ST_FAST: begin
                // Reverse diagonal returns current to the supply
                if (!zc) begin
                    g = fwd ? GATE_REV : GATE_FWD;
                end
            end
            ST_SLOW: begin
                if (!zc) begin
                    g = GATE_BRAKE;
                end
            end
            default: begin
                g = GATE_OFF;
            end
        endcase
        return g;
    endfunction : drive_fn

    // ------------------------------------------------------------------
    // Command decode and protection
    // ------------------------------------------------------------------
    assign cmd_fwd   = dir_input_a_in & ~dir_input_b_in;
    assign cmd_rev   = ~dir_input_a_in & dir_input_b_in;
    assign cmd_drive = cmd_fwd | cmd_rev;
    assign cmd_brake = dir_input_a_in & dir_input_b_in;
    assign cmd_coast = ~dir_input_a_in & ~dir_input_b_in;
    assign blocked   = fault_r | thermal_shutdown_in
                       | supply_low_lockout_in;
    assign stby_enter = cmd_coast && (stby_cnt_r == STBY_LIMIT);
    assign stby_leave = (state_r == ST_STANDBY) && !cmd_coast;

    // ------------------------------------------------------------------
    // Phase timer
    // ------------------------------------------------------------------
    hbc_phase_timer u_timer (
        .clk_sys_in  (clk_sys_in),
        .reset_in    (reset_in),
        .load_in     (tmr_load),
        .value_in    (tmr_value),
        .expired_out (tmr_done)
    );

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt   = state_r;
        dir_fwd_nxt = dir_fwd_r;
        tmr_load    = 1'b0;
        tmr_value   = BLANK_CYC;
        case (state_r)
            ST_IDLE: begin
                if (stby_enter) begin
                    state_nxt = ST_STANDBY;
                end else if (cmd_drive) begin
                    state_nxt   = ST_ON;
                    dir_fwd_nxt = cmd_fwd;
                    tmr_load    = 1'b1;
                end
            end
            ST_STANDBY: begin
                if (!cmd_coast) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_ON: begin
                if (!cmd_drive) begin
                    state_nxt = ST_IDLE;
                end else if (cmd_fwd != dir_fwd_r) begin
                    dir_fwd_nxt = cmd_fwd;
                    tmr_load    = 1'b1;
                end else if (tmr_done && current_trip_in) begin
                    state_nxt = ST_FAST;
                    tmr_load  = 1'b1;
                    tmr_value = FAST_CYC;
                end
            end
            ST_FAST: begin
                if (!cmd_drive) begin
                    state_nxt = ST_IDLE;
                end else if (tmr_done) begin
                    state_nxt = ST_COD;
                    tmr_load  = 1'b1;
                    tmr_value = COD_CYC;
                end
            end
            ST_COD: begin
                if (!cmd_drive) begin
                    state_nxt = ST_IDLE;
                end else if (tmr_done) begin
                    state_nxt = ST_SLOW;
                    tmr_load  = 1'b1;
                    tmr_value = SLOW_CYC;
                end
            end
            ST_SLOW: begin
                if (!cmd_drive) begin
                    state_nxt = ST_IDLE;
                end else if (tmr_done) begin
                    state_nxt   = ST_ON;
                    dir_fwd_nxt = cmd_fwd;
                    tmr_load    = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            state_r   <= ST_IDLE;
            dir_fwd_r <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            dir_fwd_r <= dir_fwd_nxt;
        end
    end

    // Counts cycles with both inputs low, saturating at the limit
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            stby_cnt_r <= '0;
        end else if (!cmd_coast) begin
            stby_cnt_r <= '0;
        end else if (stby_cnt_r != STBY_LIMIT) begin
            stby_cnt_r <= stby_cnt_r + STBY_W'(1);
        end
    end

    // Set wins over clear so a short seen on the clearing cycle is kept
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            fault_r <= 1'b0;
        end else if (short_fault_protect_in) begin
            fault_r <= 1'b1;
        end else if (stby_leave || load_supply_restart_in) begin
            fault_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            power_en_r <= 1'b1;
        end else begin
            power_en_r <= (state_nxt != ST_STANDBY);
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            gate_r <= GATE_RESET;
        end else if (blocked) begin
            gate_r <= GATE_OFF;
        end else begin
            gate_r <= drive_fn(state_r, dir_fwd_r, cmd_brake,
                               zero_current_in);
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign bridge_out_a_hi_out = gate_r[GATE_HI_A];
    assign bridge_out_a_lo_out = gate_r[GATE_LO_A];
    assign bridge_out_b_hi_out = gate_r[GATE_HI_B];
    assign bridge_out_b_lo_out = gate_r[GATE_LO_B];
    assign charge_pump_en_out  = power_en_r;
    assign regulator_en_out    = power_en_r;
    assign standby_out         = ~power_en_r;
    assign fault_out           = fault_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    AST_FWD_DRIVE: assert property (
        (state_r == ST_ON && dir_fwd_r && !blocked)
        |=> (bridge_out_a_hi_out && bridge_out_b_lo_out
             && !bridge_out_a_lo_out && !bridge_out_b_hi_out))
        else $error("forward drive pattern wrong");

    AST_REV_DRIVE: assert property (
        (state_r == ST_ON && !dir_fwd_r && !blocked)
        |=> (gate_r == GATE_REV))
        else $error("reverse drive pattern wrong");

    AST_FWD_CHOP: assert property (
        (state_r == ST_FAST && dir_fwd_r && !zero_current_in && !blocked)
        |=> (!bridge_out_a_hi_out && bridge_out_a_lo_out
             && bridge_out_b_hi_out))
        else $error("forward fast decay pattern wrong");

    AST_REV_CHOP: assert property (
        (state_r == ST_FAST && !dir_fwd_r && !zero_current_in && !blocked)
        |=> (bridge_out_a_hi_out && !bridge_out_a_lo_out
             && !bridge_out_b_hi_out && bridge_out_b_lo_out))
        else $error("reverse fast decay pattern wrong");

    AST_SLOW_DECAY: assert property (
        (state_r == ST_SLOW && !zero_current_in && !blocked)
        |=> (bridge_out_a_lo_out && bridge_out_b_lo_out
             && !bridge_out_a_hi_out && !bridge_out_b_hi_out))
        else $error("slow decay pattern wrong");

    AST_BRAKE: assert property (
        (state_r == ST_IDLE && cmd_brake && !blocked)
        |=> (gate_r == GATE_BRAKE))
        else $error("brake pattern wrong");

    AST_COAST: assert property (
        (state_r == ST_IDLE && cmd_coast) |=> (gate_r == GATE_OFF))
        else $error("coast not high impedance");

    AST_STBY_ENTRY: assert property (
        $rose(standby_out)
        |-> ($past(stby_cnt_r) == STBY_LIMIT && $past(cmd_coast)))
        else $error("standby entered too early");

    AST_STBY_POWER: assert property (
        (state_r == ST_STANDBY) |-> (!charge_pump_en_out && !regulator_en_out))
        else $error("power not cut in standby");

    AST_TRIP: assert property (
        (state_r == ST_ON && tmr_done && current_trip_in && cmd_drive
         && (cmd_fwd == dir_fwd_r))
        |=> (state_r == ST_FAST)
        ##1 (gate_r != (dir_fwd_r ? GATE_FWD : GATE_REV)))
        else $error("trip did not end on-period");

    AST_BLANK: assert property (
        (state_r == ST_ON && !tmr_done) |=> (state_r != ST_FAST))
        else $error("trip acted during blanking");

    AST_FAULT_OFF: assert property (
        short_fault_protect_in |=> (fault_out ##1 (gate_r == GATE_OFF)))
        else $error("short did not disable outputs");

    AST_FAULT_HOLD: assert property (
        (fault_r && !stby_leave && !load_supply_restart_in) |=> fault_r)
        else $error("fault cleared without cause");

    AST_PROTECT: assert property (
        (thermal_shutdown_in || supply_low_lockout_in) |=> (gate_r == GATE_OFF))
        else $error("drivers on during shutdown");

    AST_ZERO_CUR: assert property (
        ((state_r == ST_FAST || state_r == ST_SLOW) && zero_current_in)
        |=> (gate_r == GATE_OFF))
        else $error("rectification on at zero current");

    AST_DEAD_TIME: assert property (
        (state_r == ST_FAST && tmr_done && cmd_drive)
        |=> (state_r == ST_COD) ##1 (gate_r == GATE_OFF))
        else $error("dead time not enforced");

    AST_RESTART: assert property (
        (state_r == ST_SLOW && tmr_done && cmd_drive) |=> (state_r == ST_ON))
        else $error("off-time expiry did not restart drive");

    COV_FWD: cover property (state_r == ST_ON && dir_fwd_r ##1 !blocked);
    COV_CHOP: cover property (state_r == ST_SLOW ##1 state_r == ST_ON);
    COV_STBY: cover property (state_r == ST_STANDBY ##1 state_r == ST_IDLE);
    COV_FAULT: cover property ($rose(fault_r));

endmodule : hbc_core

//--- src/hbc_pkg.sv
/*
 * Shared constants for the full-bridge current-chopping controller:
 * timing counts at the system clock rate, gate bit layout, FSM states.
 * Assumes a 25 MHz system clock; all times are converted from ns.
 */
package hbc_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 40;
    localparam int TMR_W           = 10;
    localparam int STBY_W          = 20;

    // Blanking at start of each on-period (typical figure)
    localparam int BLANK_TIME_NS   = 3000;
    localparam int BLANK_CYC_I     = BLANK_TIME_NS / CLK_PERIOD_NS;
    // Fixed off-time (typical figure)
    localparam int OFF_TIME_NS     = 25000;
    localparam int OFF_CYC_I       = OFF_TIME_NS / CLK_PERIOD_NS;
    // Fast decay takes half of the off-time
    localparam int FAST_CYC_I      = OFF_CYC_I / 2;
    // Crossover dead time, least figure, rounded up
    localparam int COD_TIME_NS     = 50;
    localparam int COD_CYC_I       = (COD_TIME_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    // Slow decay fills what is left of the off-time
    localparam int SLOW_CYC_I      = OFF_CYC_I - FAST_CYC_I - COD_CYC_I;
    // Both inputs low for longer than this enters standby
    localparam int STANDBY_TIME_NS = 1000000;
    localparam int STANDBY_CYC_DEF = STANDBY_TIME_NS / CLK_PERIOD_NS;

    localparam logic [TMR_W-1:0] BLANK_CYC = TMR_W'(BLANK_CYC_I);
    localparam logic [TMR_W-1:0] FAST_CYC  = TMR_W'(FAST_CYC_I);
    localparam logic [TMR_W-1:0] COD_CYC   = TMR_W'(COD_CYC_I);
    localparam logic [TMR_W-1:0] SLOW_CYC  = TMR_W'(SLOW_CYC_I);

    // ------------------------------------------------------------------
    // Gate bit layout {hi_a, lo_a, hi_b, lo_b}
    // ------------------------------------------------------------------
    localparam int GATE_HI_A = 3;
    localparam int GATE_LO_A = 2;
    localparam int GATE_HI_B = 1;
    localparam int GATE_LO_B = 0;
    localparam logic [3:0] GATE_OFF   = 4'h0;
    localparam logic [3:0] GATE_FWD   = 4'b1001;
    localparam logic [3:0] GATE_REV   = 4'b0110;
    localparam logic [3:0] GATE_BRAKE = 4'b0101;
    localparam logic [3:0] GATE_RESET = 4'h0;

    // ------------------------------------------------------------------
    // Bridge sequencer states, Gray coded from ST_ON through ST_SLOW
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ON      = 3'b001,
        ST_FAST    = 3'b011,
        ST_COD     = 3'b010,
        ST_SLOW    = 3'b110,
        ST_STANDBY = 3'b100
    } hbc_state_type;

endpackage : hbc_pkg

//--- src/hbc_phase_timer.sv
/*
 * Down counter that times one phase of the bridge sequence.
 * Assumes the caller loads it on the cycle it enters a timed phase.
 */
`timescale 1ns/1ps
module hbc_phase_timer
    import hbc_pkg::*;
(
    input  wire logic             clk_sys_in,  // System clock
    input  wire logic             reset_in,    // Async reset, high
    input  wire logic             load_in,     // Load new count
    input  wire logic [TMR_W-1:0] value_in,    // Count to load
    output logic                  expired_out  // Count has reached zero
);

    logic [TMR_W-1:0] cnt_r;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_r <= '0;
        end else if (load_in) begin
            cnt_r <= value_in;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - TMR_W'(1);
        end
    end

    assign expired_out = (cnt_r == '0);

endmodule : hbc_phase_timer

//--- test/hbc_ctrl_model.sv
/* Controller model that drives the two direction inputs of the bridge.
   Assumes the bridge controller's clock and its standby flag. */
`timescale 1ns/1ps
module hbc_ctrl_model #(
    parameter int WAKE_CYC = 10          // Settle wait after standby exit
)(
    input  wire logic clk_sys_in,        // System clock
    input  wire logic reset_in,          // Async reset, high
    input  wire logic cmd_a_in,          // Wanted level, input A
    input  wire logic cmd_b_in,          // Wanted level, input B
    input  wire logic standby_in,        // Device standby flag
    output logic      dir_a_out,         // Direction input A
    output logic      dir_b_out          // Direction input B
);
    logic        stby_r;
    int unsigned wait_r;
    logic        hold;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            stby_r <= 1'b0;
            wait_r <= 0;
        end else begin
            stby_r <= standby_in;
            if (stby_r && !standby_in) begin
                wait_r <= WAKE_CYC;
            end else if (wait_r != 0) begin
                wait_r <= wait_r - 1;
            end
        end
    end
    // Coast while the charge pump settles
    assign hold      = (wait_r != 0) || (stby_r && !standby_in);
    assign dir_a_out = !hold && cmd_a_in;
    assign dir_b_out = !hold && cmd_b_in;
endmodule : hbc_ctrl_model

//--- test/hbc_core_test.sv
/* Self-checking bench of the bridge controller with a controller model.
   Assumes a 25 MHz clock and a shortened standby delay. */
`timescale 1ns/1ps
module hbc_core_test;
    import hbc_pkg::*;
    logic clk = 0, rst = 1, ca = 0, cb = 0, da, db, trip = 0, zc = 0;
    logic shrt = 0, hot = 0, low = 0, rstrt = 0;
    logic ah, al, bh, bl, cp, rg, sb, flt;
    logic [7:0] exp_q[$];
    logic [7:0] e;
    logic [31:0] lfsr = 32'h0000_36d4;
    int num_errors = 0, cmp_count = 0, n;
    event chk;

    hbc_ctrl_model mdl (.clk_sys_in(clk), .reset_in(rst), .cmd_a_in(ca),
        .cmd_b_in(cb), .standby_in(sb), .dir_a_out(da), .dir_b_out(db));
    hbc_core #(.STANDBY_CYC(20)) uut (.clk_sys_in(clk), .reset_in(rst),
        .dir_input_a_in(da), .dir_input_b_in(db), .current_trip_in(trip),
        .zero_current_in(zc), .short_fault_protect_in(shrt),
        .thermal_shutdown_in(hot), .supply_low_lockout_in(low),
        .load_supply_restart_in(rstrt), .bridge_out_a_hi_out(ah),
        .bridge_out_a_lo_out(al), .bridge_out_b_hi_out(bh),
        .bridge_out_b_lo_out(bl), .charge_pump_en_out(cp),
        .regulator_en_out(rg), .standby_out(sb), .fault_out(flt));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step

    task automatic expect_out(input logic [3:0] g, input logic f,
                              input logic s);
        exp_q.push_back({~s, ~s, f, s, g});
        ->chk;
    endtask : expect_out

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    // Oldest note against the outputs seen now
    initial begin
        forever begin
            @(chk);
            while (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                cmp_count++;
                if ({rg, cp, flt, sb, ah, al, bh, bl} !== e) begin
                    num_errors++;
                    $display("CHECK FAILED outputs exp %b seen %b", e,
                             {rg, cp, flt, sb, ah, al, bh, bl});
                end
            end
        end
    end

    initial begin
        #(40 * 5000);
        num_errors++;
        end_sim();
    end

    initial begin
        step(10);
        rst = 0;
        // Random directions, trip noise inside blanking
        for (int i = 0; i < 6; i++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            ca = lfsr[0];
            cb = !lfsr[0];
            trip = lfsr[1];
            step(3);
            expect_out(lfsr[0] ? GATE_FWD : GATE_REV, 0, 0);
            trip = 0;
        end
        $display("test directions done");
        for (int d = 0; d < 2; d++) begin
            ca = (d == 0);
            cb = (d == 1);
            trip = 1;
            step(40);
            expect_out(d ? GATE_REV : GATE_FWD, 0, 0);
            step(60);
            expect_out(d ? GATE_FWD : GATE_REV, 0, 0);
            trip = 0;
            n = 0;
            while (ah !== 1'b0 || bh !== 1'b0) begin
                step(1);
                n++;
                if (n > 400) break;
            end
            expect_out(GATE_OFF, 0, 0);
            step(3);
            expect_out(GATE_BRAKE, 0, 0);
            zc = 1;
            step(2);
            expect_out(GATE_OFF, 0, 0);
            zc = 0;
            step(320);
            expect_out(d ? GATE_REV : GATE_FWD, 0, 0);
        end
        $display("test chop done");
        ca = 1;
        cb = 1;
        step(3);
        expect_out(GATE_BRAKE, 0, 0);
        ca = 0;
        cb = 0;
        step(3);
        expect_out(GATE_OFF, 0, 0);
        step(25);
        expect_out(GATE_OFF, 0, 1);
        ca = 1;
        step(40);
        expect_out(GATE_FWD, 0, 0);
        $display("test standby done");
        shrt = 1;
        step(1);
        shrt = 0;
        step(2);
        expect_out(GATE_OFF, 1, 0);
        ca = 0;
        cb = 1;
        step(5);
        expect_out(GATE_OFF, 1, 0);
        rstrt = 1;
        step(1);
        rstrt = 0;
        step(4);
        expect_out(GATE_REV, 0, 0);
        shrt = 1;
        step(1);
        shrt = 0;
        cb = 0;
        step(30);
        expect_out(GATE_OFF, 1, 1);
        ca = 1;
        step(40);
        expect_out(GATE_FWD, 0, 0);
        $display("test fault done");
        for (int k = 0; k < 2; k++) begin
            hot = (k == 0);
            low = (k == 1);
            step(2);
            expect_out(GATE_OFF, 0, 0);
            hot = 0;
            low = 0;
            step(3);
            expect_out(GATE_FWD, 0, 0);
        end
        $display("test protection done");
        step(2);
        end_sim();
    end
endmodule : hbc_core_test
